// *** rtl/pifb_pkg.sv ***
// Purpose: constants and types shared by the peripheral interrupt flag bank
// Assumes: one clock, 32-bit register bus, one register per aligned word
// Notes: flag and enable registers are 8 bits wide in the low lane
`default_nettype none

package pifb_pkg;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] PIFB_OFF_FLAGS2 = 8'h00;
   localparam logic [7:0] PIFB_OFF_FLAGS3 = 8'h04;
   localparam logic [7:0] PIFB_OFF_FLAGS4 = 8'h08;
   localparam logic [7:0] PIFB_OFF_EN2 = 8'h0c;
   localparam logic [7:0] PIFB_OFF_EN3 = 8'h10;
   localparam logic [7:0] PIFB_OFF_EN4 = 8'h14;
   localparam logic [7:0] PIFB_OFF_CTRL = 8'h18;
   localparam logic [7:0] PIFB_OFF_STAT = 8'h1c;
   localparam logic [7:0] PIFB_OFF_MASK = 8'h20;

   // ************************************************************
   // implemented bits of each group (flags and enables alike)
   // ************************************************************
   localparam logic [7:0] PIFB_IMPL2 = 8'hf9;
   localparam logic [7:0] PIFB_IMPL3 = 8'h3a;
   localparam logic [7:0] PIFB_IMPL4 = 8'h03;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int PIFB_B_OSC_FAIL = 7;
   localparam int PIFB_B_CMP_TWO = 6;
   localparam int PIFB_B_CMP_ONE = 5;
   localparam int PIFB_B_NV_DONE = 4;
   localparam int PIFB_B_SER1_COLL = 3;
   localparam int PIFB_B_CAP_TWO = 0;
   localparam int PIFB_B_CAP_FOUR = 5;
   localparam int PIFB_B_CAP_THREE = 4;
   localparam int PIFB_B_TMR_SIX = 3;
   localparam int PIFB_B_TMR_FOUR = 1;
   localparam int PIFB_B_SER2_COLL = 1;
   localparam int PIFB_B_SER2_DONE = 0;
   localparam int PIFB_B_GLOBAL_EN = 7;
   localparam int PIFB_B_PERIPH_EN = 6;

   // ************************************************************
   // reset values and widths
   // ************************************************************
   localparam logic [7:0] PIFB_RST_BYTE = 8'h00;
   localparam int PIFB_STAT_W = 3;
   localparam logic [2:0] PIFB_RST_STAT = 3'h0;
   localparam logic [31:0] PIFB_RST_WORD = 32'h0000_0000;

   // bus slave states, one-hot
   typedef enum logic [3:0] {
      PIFB_ST_IDLE = 4'b0001,
      PIFB_ST_WRITE = 4'b0010,
      PIFB_ST_RD_WAIT = 4'b0100,
      PIFB_ST_RD_DONE = 4'b1000
   } pifb_state_t;

   // word address match, used for both write and read decode
   function automatic logic pifb_hit(input logic [7:0] addr,
                                     input logic [7:0] off);
      pifb_hit = (addr[7:2] == off[7:2]);
   endfunction

   // any flag pending together with its enable
   function automatic logic pifb_any(input logic [7:0] flags,
                                     input logic [7:0] enables);
      pifb_any = |(flags & enables);
   endfunction

endpackage

`default_nettype wire

// *** rtl/pifb_flag_reg.sv ***
// Purpose: one 8-bit group of sticky peripheral flags
// Assumes: hw_set bits are one-cycle pulses from the peripherals
// Notes: a hardware set in the cycle of a software write wins
`default_nettype none

module pifb_flag_reg
   import pifb_pkg::*;
#(
   parameter logic [7:0] IMPL_MASK = 8'hff
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] hw_set,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] flags,
   output logic set_evt
);

   typedef struct packed {
      logic [7:0] flags;
   } pifb_flag_t;

   pifb_flag_t cur;
   pifb_flag_t next_cur;

   // ************************************************************
   // next value
   // ************************************************************
   // set ORed after write, so an event is never lost to a clear
   always_comb begin
      next_cur = cur;
      if (wr_en) begin
         next_cur.flags = wr_data;
      end
      next_cur.flags = (next_cur.flags | hw_set) & IMPL_MASK;
   end

   // async reset to zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cur.flags <= PIFB_RST_BYTE; // RULE_04
      end else begin
         cur <= next_cur;
      end
   end

   assign flags = cur.flags;
   assign set_evt = |(hw_set & IMPL_MASK);

endmodule

`default_nettype wire

// *** rtl/pifb_sticky_status.sv ***
// Purpose: sticky event status, cleared by a read
// Assumes: rd_clr pulses once per status read
// Notes: a set in the clearing cycle survives the clear
`default_nettype none

module pifb_sticky_status
   import pifb_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [PIFB_STAT_W-1:0] sets,
   input wire logic rd_clr,
   output logic [PIFB_STAT_W-1:0] status
);

   typedef struct packed {
      logic [PIFB_STAT_W-1:0] status;
   } pifb_stat_t;

   pifb_stat_t cur;
   pifb_stat_t next_cur;

   // read clears, sets win
   always_comb begin
      next_cur = cur;
      if (rd_clr) begin
         next_cur.status = PIFB_RST_STAT;
      end
      next_cur.status = next_cur.status | sets;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cur.status <= PIFB_RST_STAT;
      end else begin
         cur <= next_cur;
      end
   end

   assign status = cur.status;

endmodule

`default_nettype wire

// *** rtl/pifb_flag_bank.sv ***
// Purpose: peripheral interrupt flag bank, groups two to four, on AHB-Lite
// Assumes: single word transfers, one slave, event inputs are pulses
// Notes: reads take one wait state, writes none; response always OKAY
//
// How it works
// [RULE_01] each flag sets on its event whatever the enables hold.
// [RULE_02] software should clear a flag before enabling its source.
// [RULE_03] unimplemented flag bits read zero and ignore writes.
// [RULE_04] every flag resets to zero on any reset.
// [RULE_05] group two holds osc fail, comparators, nv write, collision, ccp2.
// [RULE_06] group three holds ccp4, ccp3, timer six and timer four matches.
// [RULE_07] serial two collision sets on detection and holds until cleared.
// [RULE_08] serial two done sets on completion and holds until cleared.
// [RULE_09] each flag reads one while pending and is writable by software.
// [RULE_10] a request is raised while any flag meets its own enable bit.
//
// The address map and register access over AHB-Lite were left to the implementer.
`default_nettype none

module pifb_flag_bank
   import pifb_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic osc_fail_event,
   input wire logic comparator_two_event,
   input wire logic comparator_one_event,
   input wire logic nv_write_done_event,
   input wire logic serial_one_collision_event,
   input wire logic capcomp_two_event,
   input wire logic capcomp_four_event,
   input wire logic capcomp_three_event,
   input wire logic timer_six_match_event,
   input wire logic timer_four_match_event,
   input wire logic serial_two_collision_event,
   input wire logic serial_two_done_event,
   output logic periph_irq_req,
   output logic cpu_irq_req,
   output logic irq
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      pifb_state_t state;
      logic [7:0] addr;
      logic [31:0] rdata;
      logic [7:0] en2;
      logic [7:0] en3;
      logic [7:0] en4;
      logic [7:0] ctrl;
      logic [PIFB_STAT_W-1:0] mask;
   } pifb_main_t;

   pifb_main_t cur;
   pifb_main_t next_cur;

   logic [7:0] set2;
   logic [7:0] set3;
   logic [7:0] set4;
   logic [7:0] flags2;
   logic [7:0] flags3;
   logic [7:0] flags4;
   logic [PIFB_STAT_W-1:0] stat_sets;
   logic [PIFB_STAT_W-1:0] status;
   logic accept;
   logic in_write;
   logic wr_f2;
   logic wr_f3;
   logic wr_f4;
   logic rd_clr;
   logic [31:0] rd_mux;

   // ************************************************************
   // event mapping onto flag positions
   // ************************************************************
   // each group gathers its peripheral pulses; no enable gating
   always_comb begin
      set2 = PIFB_RST_BYTE;
      set3 = PIFB_RST_BYTE;
      set4 = PIFB_RST_BYTE;
      set2[PIFB_B_OSC_FAIL] = osc_fail_event; // RULE_05
      set2[PIFB_B_CMP_TWO] = comparator_two_event; // RULE_05
      set2[PIFB_B_CMP_ONE] = comparator_one_event; // RULE_05
      set2[PIFB_B_NV_DONE] = nv_write_done_event; // RULE_05
      set2[PIFB_B_SER1_COLL] = serial_one_collision_event; // RULE_05
      set2[PIFB_B_CAP_TWO] = capcomp_two_event; // RULE_05
      set3[PIFB_B_CAP_FOUR] = capcomp_four_event; // RULE_06
      set3[PIFB_B_CAP_THREE] = capcomp_three_event; // RULE_06
      set3[PIFB_B_TMR_SIX] = timer_six_match_event; // RULE_06
      set3[PIFB_B_TMR_FOUR] = timer_four_match_event; // RULE_06
      set4[PIFB_B_SER2_COLL] = serial_two_collision_event; // RULE_07
      set4[PIFB_B_SER2_DONE] = serial_two_done_event; // RULE_08
   end

   // ************************************************************
   // bus decode
   // ************************************************************
   // writes land in the data phase, straight from the held address
   assign accept = hsel && hready && htrans[1];
   assign in_write = (cur.state == PIFB_ST_WRITE);
   assign wr_f2 = in_write && pifb_hit(cur.addr, PIFB_OFF_FLAGS2); // RULE_09
   assign wr_f3 = in_write && pifb_hit(cur.addr, PIFB_OFF_FLAGS3); // RULE_09
   assign wr_f4 = in_write && pifb_hit(cur.addr, PIFB_OFF_FLAGS4); // RULE_09
   assign rd_clr = (cur.state == PIFB_ST_RD_WAIT) &&
                   pifb_hit(cur.addr, PIFB_OFF_STAT);

   // ************************************************************
   // flag groups
   // ************************************************************
   pifb_flag_reg #(
      .IMPL_MASK(PIFB_IMPL2)
   ) u_flags2 (
      .core_clk(core_clk),
      .nrst(nrst),
      .hw_set(set2), // RULE_01
      .wr_en(wr_f2),
      .wr_data(hwdata[7:0]),
      .flags(flags2),
      .set_evt(stat_sets[0])
   );

   pifb_flag_reg #(
      .IMPL_MASK(PIFB_IMPL3)
   ) u_flags3 (
      .core_clk(core_clk),
      .nrst(nrst),
      .hw_set(set3), // RULE_01
      .wr_en(wr_f3),
      .wr_data(hwdata[7:0]),
      .flags(flags3),
      .set_evt(stat_sets[1])
   );

   pifb_flag_reg #(
      .IMPL_MASK(PIFB_IMPL4)
   ) u_flags4 (
      .core_clk(core_clk),
      .nrst(nrst),
      .hw_set(set4), // RULE_01
      .wr_en(wr_f4),
      .wr_data(hwdata[7:0]),
      .flags(flags4),
      .set_evt(stat_sets[2])
   );

   // new-flag events per group, cleared by reading the status word
   pifb_sticky_status u_status (
      .core_clk(core_clk),
      .nrst(nrst),
      .sets(stat_sets),
      .rd_clr(rd_clr),
      .status(status)
   );

   // ************************************************************
   // read multiplexer
   // ************************************************************
   // unmapped words and unimplemented bits read as zero
   always_comb begin
      rd_mux = PIFB_RST_WORD;
      if (pifb_hit(cur.addr, PIFB_OFF_FLAGS2)) begin
         rd_mux[7:0] = flags2 & PIFB_IMPL2; // RULE_03
      end else if (pifb_hit(cur.addr, PIFB_OFF_FLAGS3)) begin
         rd_mux[7:0] = flags3 & PIFB_IMPL3; // RULE_03
      end else if (pifb_hit(cur.addr, PIFB_OFF_FLAGS4)) begin
         rd_mux[7:0] = flags4 & PIFB_IMPL4; // RULE_03
      end else if (pifb_hit(cur.addr, PIFB_OFF_EN2)) begin
         rd_mux[7:0] = cur.en2;
      end else if (pifb_hit(cur.addr, PIFB_OFF_EN3)) begin
         rd_mux[7:0] = cur.en3;
      end else if (pifb_hit(cur.addr, PIFB_OFF_EN4)) begin
         rd_mux[7:0] = cur.en4;
      end else if (pifb_hit(cur.addr, PIFB_OFF_CTRL)) begin
         rd_mux[7:0] = cur.ctrl;
      end else if (pifb_hit(cur.addr, PIFB_OFF_STAT)) begin
         rd_mux[PIFB_STAT_W-1:0] = status;
      end else if (pifb_hit(cur.addr, PIFB_OFF_MASK)) begin
         rd_mux[PIFB_STAT_W-1:0] = cur.mask;
      end
   end

   // ************************************************************
   // bus slave and control registers
   // ************************************************************
   // reads wait one cycle so a write just before is seen
   always_comb begin
      next_cur = cur;
      case (cur.state)
         PIFB_ST_IDLE, PIFB_ST_WRITE, PIFB_ST_RD_DONE: begin
            if (accept) begin
               next_cur.addr = haddr[7:0];
               next_cur.state = hwrite ? PIFB_ST_WRITE : PIFB_ST_RD_WAIT;
            end else begin
               next_cur.state = PIFB_ST_IDLE;
            end
         end
         PIFB_ST_RD_WAIT: begin
            next_cur.rdata = rd_mux;
            next_cur.state = PIFB_ST_RD_DONE;
         end
         default: begin
            next_cur.state = PIFB_ST_IDLE;
         end
      endcase
      if (in_write) begin
         if (pifb_hit(cur.addr, PIFB_OFF_EN2)) begin
            next_cur.en2 = hwdata[7:0] & PIFB_IMPL2;
         end
         if (pifb_hit(cur.addr, PIFB_OFF_EN3)) begin
            next_cur.en3 = hwdata[7:0] & PIFB_IMPL3;
         end
         if (pifb_hit(cur.addr, PIFB_OFF_EN4)) begin
            next_cur.en4 = hwdata[7:0] & PIFB_IMPL4;
         end
         if (pifb_hit(cur.addr, PIFB_OFF_CTRL)) begin
            next_cur.ctrl = hwdata[7:0];
         end
         if (pifb_hit(cur.addr, PIFB_OFF_MASK)) begin
            next_cur.mask = hwdata[PIFB_STAT_W-1:0];
         end
      end
   end

   // all control state clears on reset
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cur.state <= PIFB_ST_IDLE;
         cur.addr <= PIFB_RST_BYTE;
         cur.rdata <= PIFB_RST_WORD;
         cur.en2 <= PIFB_RST_BYTE;
         cur.en3 <= PIFB_RST_BYTE;
         cur.en4 <= PIFB_RST_BYTE;
         cur.ctrl <= PIFB_RST_BYTE;
         cur.mask <= PIFB_RST_STAT;
      end else begin
         cur <= next_cur;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign hrdata = cur.rdata;
   assign hreadyout = (cur.state != PIFB_ST_RD_WAIT);
   assign hresp = 1'b0;
   // request pairs each flag with the enable at the same position
   assign periph_irq_req = pifb_any(flags2, cur.en2) ||
                           pifb_any(flags3, cur.en3) ||
                           pifb_any(flags4, cur.en4); // RULE_10
   assign cpu_irq_req = periph_irq_req && cur.ctrl[PIFB_B_GLOBAL_EN] &&
                        cur.ctrl[PIFB_B_PERIPH_EN];
   assign irq = |(status & cur.mask);

   // ************************************************************
   // checks
   // ************************************************************
   a_set_ignores_en: assert property (@(posedge core_clk) disable iff (!nrst)
      comparator_one_event && cur.en2 == 8'h00 |=>
      flags2[PIFB_B_CMP_ONE]) // RULE_01
      else $error("flag not set with enables off");

   a_unimpl_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      (flags2 & ~PIFB_IMPL2) == 8'h00 && (flags3 & ~PIFB_IMPL3) == 8'h00 &&
      (flags4 & ~PIFB_IMPL4) == 8'h00) // RULE_03
      else $error("unimplemented flag bit set");

   a_reset_clear: assert property (@(posedge core_clk)
      $rose(nrst) |-> flags2 == 8'h00 && flags3 == 8'h00 &&
      flags4 == 8'h00) // RULE_04
      else $error("flags not zero after reset");

   a_osc_fail_pos: assert property (@(posedge core_clk) disable iff (!nrst)
      osc_fail_event |=> flags2[7] ##1 (rd_mux[7] ||
      !pifb_hit(cur.addr, PIFB_OFF_FLAGS2) || $past(wr_f2))) // RULE_05
      else $error("osc fail flag misplaced");

   a_timer_four_pos: assert property (@(posedge core_clk) disable iff (!nrst)
      timer_four_match_event |=> flags3[1]) // RULE_06
      else $error("timer four flag misplaced");

   a_coll_holds: assert property (@(posedge core_clk) disable iff (!nrst)
      flags4[1] && !wr_f4 |=> flags4[1]) // RULE_07
      else $error("collision flag dropped without write");

   a_done_sets: assert property (@(posedge core_clk) disable iff (!nrst)
      serial_two_done_event |=> flags4[0] [*1] ##0
      $past(serial_two_done_event)) // RULE_08
      else $error("done flag not set");

   a_write_reads: assert property (@(posedge core_clk) disable iff (!nrst)
      wr_f2 && set2 == 8'h00 |=>
      flags2 == ($past(hwdata[7:0]) & PIFB_IMPL2)) // RULE_09
      else $error("flag write not stored");

   a_read_value: assert property (@(posedge core_clk) disable iff (!nrst)
      cur.state == PIFB_ST_RD_WAIT && pifb_hit(cur.addr, PIFB_OFF_FLAGS3)
      |=> hreadyout && hrdata[7:0] == $past(flags3)) // RULE_09
      else $error("flag read wrong");

   a_req_follows: assert property (@(posedge core_clk) disable iff (!nrst)
      periph_irq_req == (|(flags2 & cur.en2) | |(flags3 & cur.en3) |
      |(flags4 & cur.en4))) // RULE_10
      else $error("request not matching flags and enables");

endmodule

`default_nettype wire

// *** rtl/unused_placeholder_never.sv ***
`default_nettype none
`default_nettype wire

// *** dv/pifb_periph_model.sv ***
// Purpose: peripheral side model, raises one-cycle event pulses
// Assumes: req is held steady while go is high
// Notes: pins sit low between pulses, as the real peripherals leave them
`default_nettype none

module pifb_periph_model (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic go,
   input wire logic [11:0] req,
   output logic [11:0] ev
);
   timeunit 1ns;
   timeprecision 1ps;

   // one pulse per request; a level would set the flag every cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ev <= 12'h000;
      end else begin
         ev <= go ? req : 12'h000;
      end
   end
endmodule

`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the peripheral interrupt flag bank
// Assumes: single AHB-Lite master, hready taken from the slave
// Notes: random register traffic from a fixed seed, corner cases by hand
`default_nettype none

module tb_top
   import pifb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // signals and instances
   // ************************************************************
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic go = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [11:0] req = 12'h000;
   wire logic hready;
   wire logic [11:0] ev;
   logic [31:0] hrdata;
   logic hreadyout, hresp, periph_irq_req, cpu_irq_req, irq;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [7:0] fl [3];
   logic [7:0] en [3];
   logic [7:0] foff [3] = '{PIFB_OFF_FLAGS2, PIFB_OFF_FLAGS3, PIFB_OFF_FLAGS4};
   logic [7:0] eoff [3] = '{PIFB_OFF_EN2, PIFB_OFF_EN3, PIFB_OFF_EN4};
   // group and bit of each event pin, in port order
   int ev_grp [12] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 2};
   int ev_bit [12] = '{7, 6, 5, 4, 3, 0, 5, 4, 3, 1, 1, 0};

   // one slave only, so its ready is the bus ready
   assign hready = hreadyout;

   always #5 core_clk = ~core_clk;

   pifb_flag_bank DUT (
      .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp),
      .osc_fail_event(ev[0]), .comparator_two_event(ev[1]),
      .comparator_one_event(ev[2]), .nv_write_done_event(ev[3]),
      .serial_one_collision_event(ev[4]), .capcomp_two_event(ev[5]),
      .capcomp_four_event(ev[6]), .capcomp_three_event(ev[7]),
      .timer_six_match_event(ev[8]), .timer_four_match_event(ev[9]),
      .serial_two_collision_event(ev[10]),
      .serial_two_done_event(ev[11]),
      .periph_irq_req(periph_irq_req), .cpu_irq_req(cpu_irq_req),
      .irq(irq)
   );

   pifb_periph_model periph (
      .core_clk(core_clk), .nrst(nrst), .go(go), .req(req), .ev(ev)
   );

   // ************************************************************
   // expectations, checks and bus tasks
   // ************************************************************
   // implemented bits follow from the event placement table
   function automatic logic [7:0] impl_of(input int g);
      impl_of = 8'h00;
      for (int i = 0; i < 12; i++) begin
         if (ev_grp[i] == g) begin
            impl_of[ev_bit[i]] = 1'b1;
         end
      end
   endfunction

   function automatic logic req_of();
      req_of = |((fl[0] & en[0]) | (fl[1] & en[1]) | (fl[2] & en[2]));
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] got);
      cmp_count++;
      if (got !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, got);
      end
   endtask

   // ready is settled at the falling edge, equal to what the edge samples
   task automatic wait_rdy(output logic [31:0] d);
      int n;
      logic r;
      n = 0;
      r = 1'b0;
      while (!r && n < 50) begin
         @(negedge core_clk);
         r = (hready === 1'b1);
         d = hrdata;
         n++;
         @(posedge core_clk);
      end
      if (!r) begin
         n_mismatch++;
         $display("Error hready wait ran out");
         end_sim();
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy(rd);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy(rd);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] x;
      ahb(1'b1, a, {24'h0, d}, x);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
      logic [31:0] d;
      ahb(1'b0, a, 32'h0, d);
      check(nm, e, d);
   endtask

   // pulse lands at the next edge; flag shows one cycle after that
   task automatic fire(input logic [11:0] r);
      req <= r;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   // a hung run still reaches the verdict
   initial begin
      repeat (100000) @(posedge core_clk);
      n_mismatch++;
      $display("Error run length exceeded");
      end_sim();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      logic [31:0] d;
      logic [7:0] c;
      logic [7:0] a;
      void'($urandom(32'h7996df4a));
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      // everything cleared after power-up reset
      for (int g = 0; g < 3; g++) begin
         rchk("flags reset", foff[g], 32'h0);
         rchk("enables reset", eoff[g], 32'h0);
      end
      rchk("unmapped", 8'h24, 32'h0);
      check("irq outs", 32'h0, {28'h0, hresp, periph_irq_req, cpu_irq_req, irq});
      // each event with enables off; mask toggles to exercise irq
      for (int i = 0; i < 12; i++) begin
         c = (i % 2) ? 8'h00 : 8'h07;
         a = foff[ev_grp[i]];
         wr(PIFB_OFF_MASK, c);
         fire(12'h001 << i);
         rchk("flag set", a, 32'h1 << ev_bit[i]);
         check("irq", {31'h0, c[0]}, {30'h0, periph_irq_req, irq});
         repeat (5) @(posedge core_clk);
         rchk("flag held", a, 32'h1 << ev_bit[i]);
         rchk("status", PIFB_OFF_STAT, 32'h1 << ev_grp[i]);
         rchk("status clr", PIFB_OFF_STAT, 32'h0);
         check("irq clr", 32'h0, {31'h0, irq});
         wr(a, 8'h00);
         rchk("flag clr", a, 32'h0);
      end
      // all ones: only implemented bits may take
      for (int g = 0; g < 3; g++) begin
         wr(foff[g], 8'hff);
         rchk("flag impl", foff[g], {24'h0, impl_of(g)});
         wr(eoff[g], 8'hff);
         rchk("enable impl", eoff[g], {24'h0, impl_of(g)});
      end
      check("periph req", 32'h1, {31'h0, periph_irq_req});
      wr(8'h24, 8'hff);
      rchk("unmapped wr", 8'h24, 32'h0);
      // random flags, enables and control
      for (int k = 0; k < 24; k++) begin
         for (int g = 0; g < 3; g++) begin
            d = $urandom;
            wr(foff[g], d[7:0]);
            fl[g] = d[7:0] & impl_of(g);
            wr(eoff[g], d[15:8]);
            en[g] = d[15:8] & impl_of(g);
            rchk("flag rw", foff[g], {24'h0, fl[g]});
         end
         c = 8'($urandom);
         wr(PIFB_OFF_CTRL, c);
         // the control write landed at the last edge of wr; look one cycle on
         @(posedge core_clk);
         check("preq", {31'h0, req_of()}, {31'h0, periph_irq_req});
         check("creq", {31'h0, req_of() & c[7] & c[6]}, {31'h0, cpu_irq_req});
      end
      // second reset in mid-run clears flags that were set
      wr(foff[0], 8'hff);
      rchk("flags pre", foff[0], {24'h0, impl_of(0)});
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      for (int g = 0; g < 3; g++) begin
         rchk("flags rerst", foff[g], 32'h0);
         rchk("enables rerst", eoff[g], 32'h0);
      end
      check("irq rerst", 32'h0, {29'h0, periph_irq_req, cpu_irq_req, irq});
      end_sim();
   end
endmodule

`default_nettype wire
